// ===== rxes_regs.vh
/*
  Register indices, field positions, state codes and reset values of the
  receive-margin scan engine.
  Assumes the includer uses these names only; the file holds definitions.
*/
`ifndef RXES_REGS_VH
`define RXES_REGS_VH

// ----------------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RXES_IDX_RCAP0 12'h850
`define RXES_IDX_SCAP0 12'h855
`define RXES_IDX_COUNTS 12'h85A
`define RXES_IDX_STATUS 12'h85B
`define RXES_IDX_CFG0 12'hC7B
`define RXES_IDX_PAT0 12'hC7C
`define RXES_IDX_IGN0 12'hC81
`define RXES_IDX_MSK0 12'hC86
`define RXES_LAST_WORD 12'h004

// ----------------------------------------------------------------------
// configuration word fields
// ----------------------------------------------------------------------
`define RXES_ERRDET_BIT 24
`define RXES_SCAN_EN_BIT 23
`define RXES_CTRL_ARM 18
`define RXES_CTRL_RUN 17
`define RXES_TRIG_MSB 22
`define RXES_TRIG_LSB 19
`define RXES_PRESC_MSB 16
`define RXES_PRESC_LSB 12
`define RXES_HORZ_MSB 11
`define RXES_HORZ_LSB 0

// ----------------------------------------------------------------------
// count and status word fields
// ----------------------------------------------------------------------
`define RXES_SAMPLE_MSB 31
`define RXES_SAMPLE_LSB 16
`define RXES_ERROR_MSB 15
`define RXES_ERROR_LSB 0

// ----------------------------------------------------------------------
// state codes
// ----------------------------------------------------------------------
`define RXES_ST_WAIT 3'b000
`define RXES_ST_RESET 3'b001
`define RXES_ST_COUNT 3'b011
`define RXES_ST_END 3'b010
`define RXES_ST_CAPTURE_WAIT_STATE 3'b101
`define RXES_ST_READ 3'b100

// ----------------------------------------------------------------------
// one-hot trigger selections
// ----------------------------------------------------------------------
`define RXES_TRIG_ERR 4'h1
`define RXES_TRIG_QUAL 4'h2
`define RXES_TRIG_PIN 4'h4
`define RXES_TRIG_NOW 4'h8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RXES_CFG0_RST 32'h00800000
`define RXES_PAT_RST 160'h0
`define RXES_IGN_RST {160{1'b1}}
`define RXES_MSK_RST {{80{1'b1}}, {80{1'b0}}}

`endif

// ===== rxes_history.v
/*
  Two-cycle history of one receive data bus.
  Assumes data arrives synchronous to clk_i; shift_en_i low freezes it.
*/
`timescale 1ns/1ps

module rxes_history #(
  parameter W = 80
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // control and data
  input wire shift_en_i,
  input wire [W-1:0] data_i,
  // history
  output reg [W-1:0] cur_o,
  output reg [W-1:0] prev_o
);

  // --------------------------------------------------------------------
  // shift register
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_o <= {W{1'b0}};
      prev_o <= {W{1'b0}};
    end else if (shift_en_i) begin
      cur_o <= data_i;
      prev_o <= cur_o;
    end
  end

endmodule

// ===== rxes_engine.v
/*
  Receive-margin scan engine: counting loop, capture loop, register port.
  Assumes recovered and offset data buses synchronous to clk_i and an
  APB3 master driving the register port with word addresses times four.
*/
// Operation
// - control bit 1 requests capture, bit 0 requests counting
// - in WAIT, counting request starts count loop, capture request capture
// - RESET clears both counters, then goes to COUNT or CAPTURE_WAIT_STATE
// - COUNT accumulates in 16-bit counters; saturation freezes and ends
// - status bit 0 is done in END, READ, WAIT; bits 3:1 state
// - state codes WAIT 000 RESET 001 COUNT 011 END 010 CAPTURE_WAIT_STATE 101 READ 100
// - END returns to WAIT once counting request is cleared
// - final counts stay valid in END and WAIT for the host
// - sample counter advances once per 2^(1+prescale) qualified cycles
// - CAPTURE_WAIT_STATE shifts both histories and stops them on trigger
// - trigger select picks match, unmasked error, pin rising edge or manual trigger
// - select 0001 error, 0010 match, 0100 pin rising, 1000 immediate
// - READ presents frozen two-cycle recovered and offset data
// - horizontal offset is a 12-bit two's complement phase count
// - error mask is five words, 1 excludes offset bit, 0 includes
// - error counter adds unmasked ones of recent offset cycle, low half
// - with upper mask half used, error counter adds one per error cycle
// - match pattern is five words; host shifts it to find alignment
// - match ignore bits: set drops recovered bit, clear requires match
// - recovered capture: present cycle low 80, previous upper 80
// - offset capture: present cycle low 80, previous upper 80
// - error output is high the cycle after each unmasked-error cycle in COUNT or CAPTURE_WAIT_STATE
`timescale 1ns/1ps
`include "rxes_regs.vh"

module rxes_engine #(
  parameter DATA_W = 80,
  parameter CNT_W = 16,
  parameter ADDR_W = 14
) (
  // clock and resets
  input wire clk_i,
  input wire reset_n_i,
  input wire scan_reset_i,
  // apb3 register port
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // receive data buses
  input wire [DATA_W-1:0] recovered_bits_i,
  input wire [DATA_W-1:0] offset_bits_i,
  input wire external_capture_request_i,
  // sampler controls and events
  output reg mismatch_pulse_out_o,
  output reg [`RXES_HORZ_MSB:0] sampling_phase_shift_o,
  output reg error_detect_mode_o,
  output reg scan_enable_o
);

  localparam FIFO_W = 2 * DATA_W;
  localparam [2:0] ST_WAIT = `RXES_ST_WAIT;
  localparam [2:0] ST_RESET = `RXES_ST_RESET;
  localparam [2:0] ST_COUNT = `RXES_ST_COUNT;
  localparam [2:0] ST_END = `RXES_ST_END;
  localparam [2:0] ST_CAPTURE_WAIT_STATE = `RXES_ST_CAPTURE_WAIT_STATE;
  localparam [2:0] ST_READ = `RXES_ST_READ;
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  reg rst_meta;
  reg rst_n;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // --------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------
  reg [31:0] scan_command_field;
  reg [FIFO_W-1:0] match_pattern;
  reg [FIFO_W-1:0] match_ignore_bits;
  reg [FIFO_W-1:0] mismatch_bit_mask;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CNT_W-1:0] qualified_cycle_total;
  reg [CNT_W-1:0] mismatch_total;
  reg [32:0] presc_cnt;
  reg pin_q;

  wire run_req = scan_command_field[`RXES_CTRL_RUN];
  wire arm_req = scan_command_field[`RXES_CTRL_ARM];
  wire [3:0] trig_sel =
    scan_command_field[`RXES_TRIG_MSB:`RXES_TRIG_LSB];
  wire [4:0] cycle_divider_exponent =
    scan_command_field[`RXES_PRESC_MSB:`RXES_PRESC_LSB];
  wire scan_en = scan_command_field[`RXES_SCAN_EN_BIT];

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  wire [11:0] idx = paddr_i[13:2];
  wire [11:0] pat_off = idx - `RXES_IDX_PAT0;
  wire [11:0] ign_off = idx - `RXES_IDX_IGN0;
  wire [11:0] msk_off = idx - `RXES_IDX_MSK0;
  wire [11:0] rcap_off = idx - `RXES_IDX_RCAP0;
  wire [11:0] scap_off = idx - `RXES_IDX_SCAP0;
  wire pat_hit = (idx >= `RXES_IDX_PAT0) && (pat_off <= `RXES_LAST_WORD);
  wire ign_hit = (idx >= `RXES_IDX_IGN0) && (ign_off <= `RXES_LAST_WORD);
  wire msk_hit = (idx >= `RXES_IDX_MSK0) && (msk_off <= `RXES_LAST_WORD);
  wire rcap_hit = (idx >= `RXES_IDX_RCAP0) &&
    (rcap_off <= `RXES_LAST_WORD);
  wire scap_hit = (idx >= `RXES_IDX_SCAP0) &&
    (scap_off <= `RXES_LAST_WORD);
  wire [7:0] pat_base = {pat_off[2:0], 5'h00};
  wire [7:0] ign_base = {ign_off[2:0], 5'h00};
  wire [7:0] msk_base = {msk_off[2:0], 5'h00};
  wire [7:0] rcap_base = {rcap_off[2:0], 5'h00};
  wire [7:0] scap_base = {scap_off[2:0], 5'h00};
  wire wr_en = psel_i & penable_i & pwrite_i & pready_o;

  // --------------------------------------------------------------------
  // data histories
  // --------------------------------------------------------------------
  wire [DATA_W-1:0] r_cur;
  wire [DATA_W-1:0] r_prev;
  wire [DATA_W-1:0] s_cur;
  wire [DATA_W-1:0] s_prev;
  wire hist_shift;

  rxes_history #(
    .W(DATA_W)
  ) u_recovered_hist (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .shift_en_i(hist_shift),
    .data_i(recovered_bits_i),
    .cur_o(r_cur),
    .prev_o(r_prev)
  );

  rxes_history #(
    .W(DATA_W)
  ) u_offset_hist (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .shift_en_i(hist_shift),
    .data_i(offset_bits_i),
    .cur_o(s_cur),
    .prev_o(s_prev)
  );

  wire [FIFO_W-1:0] captured_recovered_bits = {r_prev, r_cur};
  wire [FIFO_W-1:0] captured_offset_bits = {s_prev, s_cur};

  // --------------------------------------------------------------------
  // qualifier, error detection, trigger
  // --------------------------------------------------------------------
  wire qual_match = &((captured_recovered_bits ~^ match_pattern) |
    match_ignore_bits);
  wire [FIFO_W-1:0] unmasked =
    captured_offset_bits & ~mismatch_bit_mask;
  wire any_err = |unmasked;
  wire upper_used = ~&mismatch_bit_mask[FIFO_W-1:DATA_W];
  wire pin_rise = external_capture_request_i & ~pin_q;
  wire trigger = ((trig_sel == `RXES_TRIG_ERR) && any_err) ||
    ((trig_sel == `RXES_TRIG_QUAL) && qual_match) ||
    ((trig_sel == `RXES_TRIG_PIN) && pin_rise) ||
    (trig_sel == `RXES_TRIG_NOW);
  wire cnt_sat = (qualified_cycle_total == CNT_MAX) ||
    (mismatch_total == CNT_MAX);

  // freeze on trigger and while results are on show
  assign hist_shift = !((state == ST_CAPTURE_WAIT_STATE) && trigger) &&
    (state != ST_READ);

  function [7:0] ones_count;
    input [DATA_W-1:0] v;
    integer i;
    begin
      ones_count = 8'h00;
      for (i = 0; i < DATA_W; i = i + 1) begin
        ones_count = ones_count + {7'h00, v[i]};
      end
    end
  endfunction

  wire [7:0] err_lo = ones_count(unmasked[DATA_W-1:0]);
  wire [7:0] err_add = upper_used ? {7'h00, any_err} : err_lo;
  wire [CNT_W:0] err_sum = {1'b0, mismatch_total} +
    {{(CNT_W-7){1'b0}}, err_add};
  wire [32:0] presc_top = (33'h000000001 <<
    ({1'b0, cycle_divider_exponent} + 6'h01)) - 33'h000000001;

  // --------------------------------------------------------------------
  // state machine
  // --------------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_WAIT: begin
        if (run_req || arm_req) begin
          next_state = ST_RESET;
        end
      end
      ST_RESET: begin
        if (run_req) begin
          next_state = ST_COUNT;
        end else if (arm_req) begin
          next_state = ST_CAPTURE_WAIT_STATE;
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_COUNT: begin
        if (cnt_sat || !run_req) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        if (!run_req) begin
          next_state = ST_WAIT;
        end
      end
      ST_CAPTURE_WAIT_STATE: begin
        if (trigger || !arm_req) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        if (!arm_req) begin
          next_state = ST_WAIT;
        end
      end
      default: begin
        next_state = ST_WAIT;
      end
    endcase
    if (scan_reset_i || !scan_en) begin
      next_state = ST_WAIT;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_WAIT;
      pin_q <= 1'b0;
    end else begin
      state <= next_state;
      pin_q <= external_capture_request_i;
    end
  end

  // --------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      qualified_cycle_total <= {CNT_W{1'b0}};
      mismatch_total <= {CNT_W{1'b0}};
      presc_cnt <= 33'h000000000;
    end else if (scan_reset_i || state == ST_RESET) begin
      qualified_cycle_total <= {CNT_W{1'b0}};
      mismatch_total <= {CNT_W{1'b0}};
      presc_cnt <= 33'h000000000;
    end else if (state == ST_COUNT && !cnt_sat && qual_match) begin
      if (err_sum[CNT_W]) begin
        mismatch_total <= CNT_MAX;
      end else begin
        mismatch_total <= err_sum[CNT_W-1:0];
      end
      if (presc_cnt == presc_top) begin
        presc_cnt <= 33'h000000000;
        qualified_cycle_total <= qualified_cycle_total +
          {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        presc_cnt <= presc_cnt + 33'h000000001;
      end
    end
  end

  // --------------------------------------------------------------------
  // event and sampler outputs
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mismatch_pulse_out_o <= 1'b0;
      sampling_phase_shift_o <= {(`RXES_HORZ_MSB+1){1'b0}};
      error_detect_mode_o <= 1'b0;
      scan_enable_o <= 1'b0;
    end else begin
      mismatch_pulse_out_o <= any_err &&
        (state == ST_COUNT || state == ST_CAPTURE_WAIT_STATE);
      sampling_phase_shift_o <=
        scan_command_field[`RXES_HORZ_MSB:`RXES_HORZ_LSB];
      error_detect_mode_o <= scan_command_field[`RXES_ERRDET_BIT];
      scan_enable_o <= scan_en;
    end
  end

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_command_field <= `RXES_CFG0_RST;
      match_pattern <= `RXES_PAT_RST;
      match_ignore_bits <= `RXES_IGN_RST;
      mismatch_bit_mask <= `RXES_MSK_RST;
    end else if (wr_en) begin
      if (idx == `RXES_IDX_CFG0) begin
        scan_command_field <= pwdata_i;
      end else if (pat_hit) begin
        match_pattern[pat_base +: 32] <= pwdata_i;
      end else if (ign_hit) begin
        match_ignore_bits[ign_base +: 32] <= pwdata_i;
      end else if (msk_hit) begin
        mismatch_bit_mask[msk_base +: 32] <= pwdata_i;
      end
    end
  end

  // --------------------------------------------------------------------
  // register reads
  // --------------------------------------------------------------------
  reg [31:0] next_rdata;
  reg next_hit;
  wire done = (state == ST_WAIT) || (state == ST_END) ||
    (state == ST_READ);

  always @* begin
    next_rdata = 32'h00000000;
    next_hit = 1'b1;
    if (idx == `RXES_IDX_STATUS) begin
      next_rdata = {28'h0000000, state, done};
    end else if (idx == `RXES_IDX_COUNTS) begin
      next_rdata = {qualified_cycle_total, mismatch_total};
    end else if (idx == `RXES_IDX_CFG0) begin
      next_rdata = scan_command_field;
    end else if (rcap_hit) begin
      next_rdata = captured_recovered_bits[rcap_base +: 32];
    end else if (scap_hit) begin
      next_rdata = captured_offset_bits[scap_base +: 32];
    end else if (pat_hit) begin
      next_rdata = match_pattern[pat_base +: 32];
    end else if (ign_hit) begin
      next_rdata = match_ignore_bits[ign_base +: 32];
    end else if (msk_hit) begin
      next_rdata = mismatch_bit_mask[msk_base +: 32];
    end else begin
      next_hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // apb3 handshake
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_o <= next_rdata;
      pready_o <= 1'b1;
      pslverr_o <= !next_hit;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule

// ===== rxes_engine_properties.sv
/*
  Port assertions for the scan engine, bound to every rxes_engine.
  Assumes an apb3 host that holds each request until ready is seen.
*/
`timescale 1ns/1ps
`include "rxes_regs.vh"
module rxes_engine_checker (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // apb3 port
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [13:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // data and sampler side
  input wire [79:0] offset_bits_i,
  input wire mismatch_pulse_out_o,
  input wire [11:0] sampling_phase_shift_o,
  input wire error_detect_mode_o,
  input wire scan_enable_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire [11:0] idx = paddr_i[13:2];
  wire mapped = (idx >= `RXES_IDX_RCAP0 && idx <= `RXES_IDX_STATUS) ||
    (idx >= `RXES_IDX_CFG0 && idx <= `RXES_IDX_MSK0 + `RXES_LAST_WORD);
  wire cfg_wr = psel_i & penable_i & pwrite_i & pready_o &
    (idx == `RXES_IDX_CFG0);
  wire st_rd = pready_o & !pwrite_i & (idx == `RXES_IDX_STATUS);
  reg [31:0] cfg_seen;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      cfg_seen <= `RXES_CFG0_RST;
    else if (cfg_wr)
      cfg_seen <= pwdata_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ready_one_cycle_a: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  error_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  unmapped_error_a: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("slave error does not match address");
  done_flag_a: assert property (st_rd |->
    prdata_o[0] == (prdata_o[3:1] inside {3'b000, 3'b010, 3'b100}))
    else $error("done flag wrong for state");
  state_code_a: assert property (st_rd |->
    !(prdata_o[3:1] inside {3'b110, 3'b111}))
    else $error("unknown state code");
  phase_copy_a: assert property (cfg_wr |=> ##1
    sampling_phase_shift_o == cfg_seen[11:0])
    else $error("phase offset not copied");
  mode_copy_a: assert property (cfg_wr |=> ##1
    {error_detect_mode_o, scan_enable_o} == cfg_seen[24:23])
    else $error("mode bits not copied");
  pulse_cause_a: assert property (mismatch_pulse_out_o |->
    $past(|offset_bits_i) || $past(|offset_bits_i, 2) ||
    $past(|offset_bits_i, 3))
    else $error("mismatch pulse without offset error");
endmodule

bind rxes_engine rxes_engine_checker i_rxes_engine_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .offset_bits_i(offset_bits_i),
  .mismatch_pulse_out_o(mismatch_pulse_out_o),
  .sampling_phase_shift_o(sampling_phase_shift_o),
  .error_detect_mode_o(error_detect_mode_o),
  .scan_enable_o(scan_enable_o));

// ===== rxes_apb_host.sv
/*
  Apb3 host model issuing register transfers to the scan engine.
  Assumes the bench calls xfer; one transfer at a time.
*/
`timescale 1ns/1ps
module rxes_apb_host (
  // clock
  input wire clk_i,
  // apb3 requester
  output reg psel_o = 1'b0,
  output reg penable_o = 1'b0,
  output reg pwrite_o = 1'b0,
  output reg [13:0] paddr_o = 14'h0,
  output reg [31:0] pwdata_o = 32'h0,
  input wire [31:0] prdata_i,
  input wire pready_i,
  input wire pslverr_i
);
  task xfer(input w, input [13:0] a, input [31:0] d, output [31:0] r,
    output ok);
    integer n;
    begin
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      n = 0;
      @(posedge clk_i);
      while (pready_i !== 1'b1 && n < 8) begin
        @(posedge clk_i);
        n = n + 1;
      end
      ok = (pready_i === 1'b1);
      r = prdata_i;
      // released lines show the inverse of the last value
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwrite_o <= ~w;
      paddr_o <= ~a;
      pwdata_o <= ~d;
    end
  endtask
endmodule

// ===== tb.sv
/*
  Self-checking bench for the scan engine: reset values, counting and
  capture loops. Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`include "rxes_regs.vh"
module tb;
  reg clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg [79:0] rec = 80'h0, off = 80'h0, fix = 80'h0, ofix = 80'h0;
  reg [79:0] oidle = 80'h0, pa, pb, oa, ob, t80;
  reg hold = 1'b0, pin = 1'b0, ok, sres = 1'b0;
  wire psel, penable, pwrite, pready, pslverr;
  wire [13:0] paddr;
  wire [31:0] pwdata, prdata;
  integer miscompares = 0, tests_run = 0, seed = 84, m;
  reg [64:0] expq[$];
  reg [64:0] x;
  reg [31:0] rd, cfg;
  localparam [79:0] PAT = 80'hA5A5_0F0F_1234_5678_9ABC;

  always #50 clk_i = ~clk_i;

  rxes_engine i_rxes_engine (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .scan_reset_i(sres), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .recovered_bits_i(rec), .offset_bits_i(off),
    .external_capture_request_i(pin), .mismatch_pulse_out_o(),
    .sampling_phase_shift_o(), .error_detect_mode_o(),
    .scan_enable_o());
  rxes_apb_host i_rxes_apb_host (.clk_i(clk_i), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  function [79:0] rnd80();
    reg [95:0] t;
    begin
      t = {$random(seed), $random(seed), $random(seed)};
      rnd80 = t[79:0];
    end
  endfunction

  always @(posedge clk_i) begin
    rec <= hold ? fix : rnd80();
    off <= hold ? ofix : oidle;
  end

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (pready === 1'b1) begin
      x = expq.pop_front();
      tests_run = tests_run + 1;
      if ((prdata & x[63:32]) !== (x[31:0] & x[63:32]) ||
        pslverr !== x[64]) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h exp %h", $time, {pslverr, prdata},
          {x[64], x[31:0]});
      end
    end
  end

  task conclude;
    begin
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task acc(input w, input [11:0] a, input [31:0] d, input [31:0] k,
    input e);
    begin
      expq.push_back({e, k, d});
      i_rxes_apb_host.xfer(w, {a, 2'b00}, d, rd, ok);
      if (!ok) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t ready %h exp %h", $time, 1'b0, 1'b1);
        conclude;
      end
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    acc(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task rdc(input [11:0] a, input [31:0] e);
    acc(1'b0, a, e, 32'hFFFFFFFF, 1'b0);
  endtask

  task wr5(input [11:0] a, input [159:0] v);
    integer k;
    for (k = 0; k < 5; k = k + 1)
      wr(a + k[11:0], v[32*k +: 32]);
  endtask

  task rd5(input [11:0] a, input [159:0] v);
    integer k;
    for (k = 0; k < 5; k = k + 1)
      rdc(a + k[11:0], v[32*k +: 32]);
  endtask

  task poll(input [31:0] want, input integer lim);
    integer n;
    begin
      n = 0;
      rd = ~want;
      while (rd !== want && n < lim) begin
        acc(1'b0, `RXES_IDX_STATUS, 32'h0, 32'h0, 1'b0);
        n = n + 1;
      end
      tests_run = tests_run + 1;
      if (rd !== want) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t status %h exp %h", $time, rd, want);
        conclude;
      end
    end
  endtask

  task count_run(input [4:0] ps, input [159:0] k, input [79:0] ov,
    input [31:0] e);
    begin
      wr5(`RXES_IDX_MSK0, k);
      @(posedge clk_i) oidle <= ov;
      t80 = rnd80();
      cfg = {7'h0, 2'b11, 4'h0, 2'b01, ps, t80[11:0]};
      wr(`RXES_IDX_CFG0, cfg);
      poll(32'h6, 20);
      @(posedge clk_i) begin
        hold <= 1'b1;
        fix <= PAT;
        ofix <= ov;
      end
      repeat (8) @(posedge clk_i);
      hold <= 1'b0;
      repeat (4) @(posedge clk_i);
      wr(`RXES_IDX_CFG0, cfg & 32'hFFFDFFFF);
      poll(32'h1, 20);
      rdc(`RXES_IDX_COUNTS, e);
      $display("count run prescale %0d done", ps);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdc(`RXES_IDX_CFG0, `RXES_CFG0_RST);
    rdc(`RXES_IDX_STATUS, 32'h1);
    rd5(`RXES_IDX_PAT0, `RXES_PAT_RST);
    rd5(`RXES_IDX_IGN0, `RXES_IGN_RST);
    rd5(`RXES_IDX_MSK0, `RXES_MSK_RST);
    acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
    wr(`RXES_IDX_COUNTS, 32'hFFFFFFFF);
    rdc(`RXES_IDX_COUNTS, 32'h0);
    t80 = rnd80();
    wr(`RXES_IDX_PAT0 + 12'h1, t80[31:0]);
    rdc(`RXES_IDX_PAT0 + 12'h1, t80[31:0]);
    $display("register test done");
    wr(`RXES_IDX_CFG0, 32'h01820000);
    poll(32'h6, 20);
    @(posedge clk_i) sres <= 1'b1;
    poll(32'h1, 20);
    wr(`RXES_IDX_CFG0, 32'h01800000);
    @(posedge clk_i) sres <= 1'b0;
    rdc(`RXES_IDX_COUNTS, 32'h0);
    $display("scan reset test done");
    wr5(`RXES_IDX_PAT0, {80'h0, PAT});
    wr5(`RXES_IDX_IGN0, {{80{1'b1}}, 80'h0});
    count_run(5'd0, `RXES_MSK_RST, 80'h7, {16'd4, 16'd24});
    count_run(5'd1, {{79{1'b1}}, 1'b0, {80{1'b1}}}, 80'hF,
      {16'd2, 16'd8});
    wr5(`RXES_IDX_IGN0, {160{1'b1}});
    wr5(`RXES_IDX_MSK0, `RXES_MSK_RST);
    @(posedge clk_i) oidle <= {80{1'b1}};
    wr(`RXES_IDX_CFG0, 32'h01820000);
    poll(32'h5, 400);
    acc(1'b0, `RXES_IDX_COUNTS, 32'hFFFF, 32'hFFFF, 1'b0);
    rdc(`RXES_IDX_STATUS, 32'h5);
    wr(`RXES_IDX_CFG0, 32'h01800000);
    poll(32'h1, 20);
    acc(1'b0, `RXES_IDX_COUNTS, 32'hFFFF, 32'hFFFF, 1'b0);
    $display("saturation test done");
    wr5(`RXES_IDX_IGN0, 160'h0);
    wr5(`RXES_IDX_MSK0, {{159{1'b1}}, 1'b0});
    @(posedge clk_i) oidle <= 80'h0;
    for (m = 0; m < 4; m = m + 1) begin
      pa = rnd80();
      pb = rnd80();
      oa = rnd80();
      ob = rnd80();
      wr5(`RXES_IDX_PAT0, {pa, pb});
      wr(`RXES_IDX_CFG0, {7'h0, 2'b11, 4'h1 << m, 2'b10, 17'h0});
      if (m != 3)
        poll(32'hA, 20);
      @(posedge clk_i) begin
        hold <= 1'b1;
        fix <= pa;
        ofix <= (m == 0) ? 80'h1 : oa;
        pin <= (m == 2);
      end
      @(posedge clk_i) begin
        fix <= pb;
        ofix <= ob;
      end
      @(posedge clk_i) begin
        hold <= 1'b0;
        pin <= 1'b0;
      end
      poll(32'h9, 20);
      if (m == 1) begin
        rd5(`RXES_IDX_RCAP0, {pa, pb});
        rd5(`RXES_IDX_SCAP0, {oa, ob});
      end
      wr(`RXES_IDX_CFG0, 32'h01800000);
      poll(32'h1, 20);
      $display("capture mode %0d done", m);
    end
    conclude;
  end
endmodule
